// file: common/utx_pkg.sv
// utx_pkg: constants shared by the serial transmit / flow control block.
// assumes a 125 MHz system clock; baud divisor is supplied by the user side.
package utx_pkg;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned BREAK_BITS    = 13;
  localparam logic [3:0]  BREAK_BITS_C  = 4'(BREAK_BITS);
  localparam logic [7:0]  ERR_TIMEOUT   = 8'h74;  // 116 decimal
  localparam int unsigned RXQ_DEPTH     = 16;
  localparam int unsigned RXQ_AW        = 4;
  localparam logic [15:0] DIV_RST       = 16'h043D; // 1085 clocks, about 115200 baud
  localparam logic [31:0] TMO_RST       = 32'h0001_E848; // 125000 clocks = 1 ms

  typedef enum logic [1:0] {
    UTX_FLOW_NONE = 2'b00,
    UTX_FLOW_RTS  = 2'b01,
    UTX_FLOW_CTS  = 2'b10,
    UTX_FLOW_BOTH = 2'b11
  } utx_flow_e;

  typedef enum logic [2:0] {
    UTX_IDLE  = 3'b000,
    UTX_WAIT  = 3'b001,
    UTX_START = 3'b010,
    UTX_DATA  = 3'b011,
    UTX_STOP  = 3'b100,
    UTX_BRK   = 3'b101
  } utx_state_e;
endpackage : utx_pkg

// file: testbench/testbench.sv
// testbench: directed scenarios for utx_core against the utx_far target model.
// assumes an 8 ns clock, a short baud divisor and a short cts timeout.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] DIV = 16'h0008;
  localparam logic [31:0] TMO = 32'h0000_00C8;
  logic        clk, rst_n, rx_buf_en, wr_vld, wr_single, brk_req, rx_rd;
  logic        hold, go, cts_n, rx_vld, wr_rdy, err_vld, tx, rts_n, busy, rd_avail;
  logic [1:0]  flow_mode, char_bits;
  logic [7:0]  wr_byte, err_code;
  logic [4:0]  n_send, rx_fill;
  logic [8:0]  rx_chr, rd_chr;
  logic [15:0] bytes_written, nb;
  int          err_total, checked, cyc;

  utx_core utx_core_i (.clk(clk), .rst_n(rst_n), .flow_mode(flow_mode),
    .char_bits(char_bits), .baud_div(DIV), .tmo_cycles(TMO), .rx_buf_en(rx_buf_en),
    .wr_vld(wr_vld), .wr_byte(wr_byte), .wr_single(wr_single), .brk_req(brk_req),
    .cts_n(cts_n), .rx_vld(rx_vld), .rx_chr(rx_chr), .rx_rd(rx_rd), .wr_rdy(wr_rdy),
    .bytes_written(bytes_written), .err_vld(err_vld), .err_code(err_code), .tx(tx),
    .rts_n(rts_n), .busy(busy), .rd_chr(rd_chr), .rd_avail(rd_avail), .rx_fill(rx_fill));
  utx_far utx_far_i (.clk(clk), .rst_n(rst_n), .rts_n(rts_n), .hold(hold), .go(go),
    .n_send(n_send), .cts_n(cts_n), .rx_vld(rx_vld), .rx_chr(rx_chr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("err_total=%0d checked=%0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t bit %b exp %b", $time, g, e);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t value %h exp %h", $time, g, e);
    end
  endtask : chk_val
  task automatic reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    nb = 16'h0000;
  endtask : reset
  task automatic wt(input logic v, input int lim);
    int k;
    k = 0;
    while (tx !== v && k < lim) begin
      k++;
      @(negedge clk);
    end
    if (tx !== v) begin
      err_total++;
      $display("MISMATCH t=%0t line never reached %b", $time, v);
    end
  endtask : wt
  task automatic wr(input logic [7:0] b, input logic s);
    int k;
    k = 0;
    @(posedge clk);
    wr_vld <= 1'b1;
    wr_byte <= b;
    wr_single <= s;
    @(negedge clk);
    while (wr_rdy !== 1'b1 && k < 500) begin
      k++;
      @(negedge clk);
    end
    if (wr_rdy !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t write never accepted", $time);
    end
    @(posedge clk);
    wr_vld <= 1'b0;
    nb = nb + 16'h0001;
  endtask : wr
  task automatic rx_frame(input int n, input logic [8:0] e);
    logic [8:0] g;
    g = 9'h000;
    wt(1'b0, 400);
    repeat (DIV / 2) @(negedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (DIV) @(negedge clk);
      g[i] = tx;
    end
    repeat (DIV) @(negedge clk);
    chk_val({7'h00, g}, {7'h00, e});
    chk_bit(tx, 1'b1);
  endtask : rx_frame
  task automatic t_chars();
    @(posedge clk);
    flow_mode <= utx_pkg::UTX_FLOW_NONE;
    hold <= 1'b1;
    char_bits <= 2'b10;
    wr(8'hA5, 1'b0);
    rx_frame(8, 9'h0A5);
    @(posedge clk);
    char_bits <= 2'b01;
    wr(8'h5A, 1'b0);
    rx_frame(7, 9'h05A);
    @(posedge clk);
    char_bits <= 2'b11;
    wr(8'h3C, 1'b0);
    wr(8'h01, 1'b0);
    rx_frame(9, 9'h13C);
    chk_val(bytes_written, nb);
  endtask : t_chars
  task automatic t_break();
    int k;
    k = 0;
    // a break request is only taken while the transmitter is idle
    while (busy !== 1'b0 && k < 100) begin
      k++;
      @(negedge clk);
    end
    @(posedge clk);
    brk_req <= 1'b1;
    @(posedge clk);
    brk_req <= 1'b0;
    wt(1'b0, 50);
    k = 0;
    while (tx === 1'b0 && k < 500) begin
      k++;
      @(negedge clk);
    end
    chk_val(16'(k), 16'(13 * DIV));
    chk_bit(tx, 1'b1);
  endtask : t_break
  task automatic t_cts();
    int k;
    @(posedge clk);
    flow_mode <= utx_pkg::UTX_FLOW_CTS;
    char_bits <= 2'b10;
    hold <= 1'b1;
    wr(8'hC3, 1'b1);
    k = 0;
    while (err_vld !== 1'b1 && k < 300) begin
      k++;
      @(negedge clk);
    end
    chk_bit(err_vld, 1'b1);
    chk_val({8'h00, err_code}, {8'h00, utx_pkg::ERR_TIMEOUT});
    chk_bit(tx, 1'b1);
    chk_val(bytes_written, nb);
    chk_bit(busy, 1'b1);
    chk_bit(wr_rdy, 1'b0);
    @(posedge clk);
    hold <= 1'b0;
    rx_frame(8, 9'h0C3);
  endtask : t_cts
  task automatic rd_one();
    @(posedge clk);
    rx_rd <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
    repeat (12) @(negedge clk);
  endtask : rd_one
  task automatic t_rts(input logic [1:0] fm, input logic buf_on, input logic [4:0] n);
    reset();
    flow_mode <= fm;
    rx_buf_en <= buf_on;
    @(posedge clk);
    go <= 1'b1;
    n_send <= n;
    @(posedge clk);
    go <= 1'b0;
    repeat (100) @(negedge clk);
    chk_bit(rts_n, fm[0]);
    chk_bit(rd_avail, 1'b1);
    chk_val({7'h00, rd_chr}, 16'h0155);
    if (buf_on) chk_val({11'h000, rx_fill}, 16'h0010);
    rd_one();
    chk_bit(rts_n, 1'b0);
    chk_bit(rd_avail, buf_on);
    if (buf_on) chk_val({7'h00, rd_chr}, 16'h0156);
    if (buf_on) chk_val({11'h000, rx_fill}, 16'h0010);
  endtask : t_rts

  initial begin
    rst_n = 1'b0;
    flow_mode = utx_pkg::UTX_FLOW_NONE;
    char_bits = 2'b10;
    rx_buf_en = 1'b0;
    wr_vld = 1'b0;
    wr_byte = 8'h00;
    wr_single = 1'b0;
    brk_req = 1'b0;
    rx_rd = 1'b0;
    hold = 1'b1;
    go = 1'b0;
    n_send = 5'h00;
    err_total = 0;
    checked = 0;
    cyc = 0;
    reset();
    @(negedge clk);
    chk_bit(tx, 1'b1);
    chk_bit(rts_n, 1'b0);
    t_chars();
    t_break();
    t_cts();
    t_rts(utx_pkg::UTX_FLOW_RTS, 1'b1, 5'h11);
    t_rts(utx_pkg::UTX_FLOW_BOTH, 1'b0, 5'h01);
    t_rts(utx_pkg::UTX_FLOW_NONE, 1'b1, 5'h11);
    end_of_test();
  end
endmodule : testbench

// file: testbench/utx_far.sv
// utx_far: remote serial target, its rts feeds our cts_n, our rts_n gates its sender.
// assumes received characters reach the core as framer strobes, modelled here directly.
module utx_far (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       rts_n,
  input  wire logic       hold,
  input  wire logic       go,
  input  wire logic [4:0] n_send,
  output logic            cts_n,
  output logic            rx_vld,
  output logic [8:0]      rx_chr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] left_ff;
  logic [8:0] seq_ff;
  logic [1:0] gap_ff;
  // hold high means the far side is not ready; an open line reads high too
  assign cts_n = hold;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 5'h00;
      seq_ff <= 9'h155;
      gap_ff <= 2'h0;
      rx_vld <= 1'b0;
    end else begin
      gap_ff <= gap_ff + 2'h1;
      rx_vld <= 1'b0;
      if (go) begin
        left_ff <= n_send;
      end else if (left_ff != 5'h00 && !rts_n && gap_ff == 2'h3) begin
        rx_vld <= 1'b1;
        seq_ff <= seq_ff + 9'h001;
        left_ff <= left_ff - 5'h01;
      end
    end
  end
  // data changes every cycle outside strobes
  always_ff @(posedge clk) begin
    rx_chr <= (left_ff != 5'h00 && !rts_n && gap_ff == 2'h3) ? seq_ff : ~rx_chr;
  end
endmodule : utx_far

// file: verilog/utx_core.sv
// utx_core: serial transmitter with break, cts pause and rts receive throttle.
// assumes a framer elsewhere delivers received characters as strobes.
// Summary of operation
// (R1) a break holds tx low for thirteen bit periods, then idle
// (R2) 9-bit characters arrive as two bytes, low byte first
// (R3) rts_n output and cts_n input are active low; cts idles high
// (R4) far rts drives our cts_n, our rts_n drives far cts
// (R5) flow mode selects none, rts, cts or both
// (R6) with cts flow, wait between characters while cts deasserted
// (R7) on timeout one character stays held, its bytes counted written
// (R8) a single-character timeout reports code 116; character still sent later
// (R9) buffered receive full plus new arrival deasserts rts
// (R10) far party stops sending while rts deasserted
// (R11) rts reasserts once characters are read from the full buffer
// (R12) overflow character held outside buffer, count stays N, enters on read
// (R13) with no buffer each arrival deasserts rts until read
// (R14) tx idles high; bit period from the baud divisor
module utx_core (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] flow_mode,
  input  wire logic [1:0] char_bits,
  input  wire logic [15:0] baud_div,
  input  wire logic [31:0] tmo_cycles,
  input  wire logic       rx_buf_en,
  input  wire logic       wr_vld,
  input  wire logic [7:0] wr_byte,
  input  wire logic       wr_single,
  input  wire logic       brk_req,
  input  wire logic       cts_n,
  input  wire logic       rx_vld,
  input  wire logic [8:0] rx_chr,
  input  wire logic       rx_rd,
  output logic            wr_rdy,
  output logic [15:0]     bytes_written,
  output logic            err_vld,
  output logic [7:0]      err_code,
  output logic            tx,
  output logic            rts_n,
  output logic            busy,
  output logic [8:0]      rd_chr,
  output logic            rd_avail,
  output logic [4:0]      rx_fill
);
  utx_pkg::utx_state_e st_ff;
  logic        cts_n_s;
  logic        cts_en;
  logic        rts_en;
  logic        nine;
  logic [8:0]  sh_ff;
  logic [3:0]  nbits;
  logic [3:0]  bit_ff;
  logic [15:0] bcnt_ff;
  logic        tick;
  logic [31:0] tmo_ff;
  logic        lo_ff;
  logic [7:0]  lo_byte_ff;
  logic        single_ff;
  logic        tmo_hit;
  logic        q_hold;
  logic        q_avail;
  logic [8:0]  q_chr;
  logic [4:0]  q_fill;
  logic [19:0] brk_len_ff;

  // pulled-up pin: unconnected reads deasserted (see R3)
  utx_sync #(.RST_VAL(1'b1)) u_cts (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (cts_n),
    .dout  (cts_n_s)
  );

  utx_rxq u_rxq (
    .clk      (clk),
    .rst_n    (rst_n),
    .buf_en   (rx_buf_en),
    .in_vld   (rx_vld),
    .in_chr   (rx_chr),
    .rd       (rx_rd),
    .rd_chr   (q_chr),
    .avail    (q_avail),
    .fill     (q_fill),
    .hold_vld (q_hold)
  );

  assign cts_en = flow_mode[1];  // see (R5)
  assign rts_en = flow_mode[0];  // see (R5)
  assign nine   = (char_bits == 2'b11);
  assign nbits  = nine ? 4'd9 : ((char_bits == 2'b01) ? 4'd7 : 4'd8);
  assign tick   = (bcnt_ff == 16'h0000);
  assign tmo_hit = (tmo_ff == 32'h0000_0001);

  // bit period counter (see R14)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_ff <= utx_pkg::DIV_RST;
    end else if (st_ff == utx_pkg::UTX_IDLE || st_ff == utx_pkg::UTX_WAIT || tick) begin
      bcnt_ff <= baud_div - 16'h0001;
    end else begin
      bcnt_ff <= bcnt_ff - 16'h0001;
    end
  end

  // byte pairing for 9-bit characters (see R2)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_ff      <= 1'b0;
      lo_byte_ff <= 8'h00;
    end else if (wr_vld && wr_rdy && nine) begin
      lo_ff      <= !lo_ff;
      lo_byte_ff <= wr_byte;
    end else if (!nine) begin
      lo_ff <= 1'b0;
    end
  end

  assign wr_rdy = (st_ff == utx_pkg::UTX_IDLE) && !brk_req;

  // transmit state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= utx_pkg::UTX_IDLE;
      sh_ff     <= 9'h000;
      bit_ff    <= 4'h0;
      single_ff <= 1'b0;
      tx        <= 1'b1;
    end else begin
      case (st_ff)
        utx_pkg::UTX_IDLE: begin
          tx <= 1'b1;  // see (R14)
          if (brk_req) begin
            st_ff  <= utx_pkg::UTX_BRK;
            bit_ff <= 4'h0;
            tx     <= 1'b0;
          end else if (wr_vld && (!nine || lo_ff)) begin
            sh_ff     <= nine ? {wr_byte[0], lo_byte_ff} : {1'b0, wr_byte};  // see (R2)
            single_ff <= wr_single;
            st_ff     <= utx_pkg::UTX_WAIT;
          end
        end
        utx_pkg::UTX_WAIT: begin
          if (!cts_en || !cts_n_s) begin  // see (R6)
            st_ff <= utx_pkg::UTX_START;
            tx    <= 1'b0;
          end
        end
        utx_pkg::UTX_START: begin
          if (tick) begin
            st_ff  <= utx_pkg::UTX_DATA;
            bit_ff <= 4'h0;
            tx     <= sh_ff[0];
            sh_ff  <= sh_ff >> 1;
          end
        end
        utx_pkg::UTX_DATA: begin
          if (tick) begin
            if (bit_ff == nbits - 4'd1) begin
              st_ff <= utx_pkg::UTX_STOP;
              tx    <= 1'b1;
            end else begin
              bit_ff <= bit_ff + 4'd1;
              tx     <= sh_ff[0];
              sh_ff  <= sh_ff >> 1;
            end
          end
        end
        utx_pkg::UTX_STOP: begin
          if (tick) begin
            st_ff <= utx_pkg::UTX_IDLE;
          end
        end
        utx_pkg::UTX_BRK: begin
          tx <= 1'b0;
          if (tick) begin
            if (bit_ff == utx_pkg::BREAK_BITS_C - 4'd1) begin  // see (R1)
              st_ff <= utx_pkg::UTX_IDLE;
              tx    <= 1'b1;
            end else begin
              bit_ff <= bit_ff + 4'd1;
            end
          end
        end
        default: begin
          st_ff <= utx_pkg::UTX_IDLE;
          tx    <= 1'b1;
        end
      endcase
    end
  end

  // bytes are counted when accepted, so a held character is already counted (see R7)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bytes_written <= 16'h0000;
    end else if (wr_vld && wr_rdy) begin
      bytes_written <= bytes_written + 16'h0001;
    end
  end

  // timeout while waiting on cts; the character stays held (see R7)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmo_ff <= 32'h0000_0000;
    end else if (st_ff == utx_pkg::UTX_IDLE && wr_vld && (!nine || lo_ff)) begin
      tmo_ff <= tmo_cycles;
    end else if (st_ff == utx_pkg::UTX_WAIT && tmo_ff != 32'h0000_0000) begin
      tmo_ff <= tmo_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      err_vld  <= 1'b0;
      err_code <= 8'h00;
    end else begin
      err_vld <= 1'b0;
      if (st_ff == utx_pkg::UTX_WAIT && cts_en && cts_n_s && tmo_hit && single_ff) begin
        err_vld  <= 1'b1;  // see (R8)
        err_code <= utx_pkg::ERR_TIMEOUT;
      end
    end
  end

  // receive throttle: deassert while a character waits outside the buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rts_n <= 1'b0;
    end else begin
      rts_n <= rts_en && q_hold;  // see (R9) (R11) (R13) (R3)
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy     <= 1'b0;
      rd_chr   <= 9'h000;
      rd_avail <= 1'b0;
      rx_fill  <= 5'h00;
    end else begin
      busy     <= (st_ff != utx_pkg::UTX_IDLE);
      rd_chr   <= q_chr;
      rd_avail <= q_avail;
      rx_fill  <= q_fill;  // see (R12)
    end
  end

  // cycles spent in break, watched only by the checks below
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      brk_len_ff <= 20'h00000;
    end else if (st_ff == utx_pkg::UTX_BRK) begin
      brk_len_ff <= brk_len_ff + 20'h00001;
    end else begin
      brk_len_ff <= 20'h00000;
    end
  end

  sequence brk_start_s;
    st_ff == utx_pkg::UTX_IDLE && brk_req;
  endsequence

  sequence brk_low_s;
    !tx [*8];
  endsequence

  sequence brk_end_s;
    st_ff == utx_pkg::UTX_BRK ##1 st_ff == utx_pkg::UTX_IDLE;
  endsequence

  property brk_len_p;
    @(posedge clk) disable iff (!rst_n)
      brk_start_s |=> brk_low_s;
  endproperty
  brk_low_a: assert property (brk_len_p) else $error("break line not low"); // see (R1)

  brk_full_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R1)
    brk_end_s |-> brk_len_ff == 20'(utx_pkg::BREAK_BITS * baud_div))
    else $error("break length wrong");

  wait_cts_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R6)
    (st_ff == utx_pkg::UTX_WAIT && cts_en && cts_n_s) |=> st_ff != utx_pkg::UTX_START)
    else $error("sent while cts deasserted");

  tmo_code_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R8)
    err_vld |-> err_code == 8'h74) else $error("wrong timeout code");

  rts_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R9)
    (rts_en && q_hold) |=> rts_n) else $error("rts not deasserted");

  rts_back_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R11)
    (!q_hold) |=> !rts_n) else $error("rts not reasserted");

  fill_cap_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R12)
    q_fill <= 5'(utx_pkg::RXQ_DEPTH)) else $error("fill above depth");

  idle_high_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R14)
    (st_ff == utx_pkg::UTX_IDLE && $past(st_ff) == utx_pkg::UTX_IDLE) |-> tx)
    else $error("idle line low");

  no_flow_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R5)
    !rts_en |=> !rts_n) else $error("rts moved without flow");

  pair_wait_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R2)
    (nine && wr_vld && wr_rdy && !lo_ff) |=> st_ff == utx_pkg::UTX_IDLE)
    else $error("low byte started a character");

  byte_cnt_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R7)
    (wr_vld && wr_rdy) |=> bytes_written == $past(bytes_written) + 16'h0001)
    else $error("accepted byte not counted");

  nobuf_rts_a: assert property (@(posedge clk) disable iff (!rst_n) // see (R13)
    (rts_en && !rx_buf_en && rx_vld) ##1 rts_en |=> rts_n)
    else $error("rts stayed asserted after arrival");
endmodule : utx_core

// file: verilog/utx_rxq.sv
// utx_rxq: receive character queue with one overflow holding slot.
// assumes received characters arrive as single-cycle strobes from the framer.
module utx_rxq (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       buf_en,
  input  wire logic       in_vld,
  input  wire logic [8:0] in_chr,
  input  wire logic       rd,
  output logic [8:0]      rd_chr,
  output logic            avail,
  output logic [4:0]      fill,
  output logic            hold_vld
);
  logic [8:0]                  mem [utx_pkg::RXQ_DEPTH];
  logic [utx_pkg::RXQ_AW-1:0]  wp_ff;
  logic [utx_pkg::RXQ_AW-1:0]  rp_ff;
  logic [4:0]                  cnt_ff;
  logic [8:0]                  hold_ff;
  logic                        hv_ff;
  logic                        full;
  logic                        pop;
  logic                        push;
  logic [8:0]                  push_chr;

  assign full     = buf_en ? (cnt_ff == 5'(utx_pkg::RXQ_DEPTH)) : 1'b1;
  assign pop      = rd && buf_en && (cnt_ff != 5'h00);
  // held character enters as soon as a slot frees, else new arrival if room
  assign push     = buf_en && ((hv_ff && pop) || (!hv_ff && in_vld && (!full || pop)));
  assign push_chr = hv_ff ? hold_ff : in_chr;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= push_chr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= 5'h00;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
      cnt_ff <= cnt_ff + 5'(push) - 5'(pop);
    end
  end

  // overflow holding slot; with buf_en low it is the only storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hv_ff   <= 1'b0;
      hold_ff <= 9'h000;
    end else if (!buf_en) begin
      if (in_vld) begin
        hv_ff   <= 1'b1;
        hold_ff <= in_chr;
      end else if (rd) begin
        hv_ff <= 1'b0;
      end
    end else if (hv_ff) begin
      if (pop) hv_ff <= 1'b0;  // see (R12)
    end else if (in_vld && full && !pop) begin
      hv_ff   <= 1'b1;
      hold_ff <= in_chr;
    end
  end

  assign rd_chr   = buf_en ? mem[rp_ff] : hold_ff;
  assign avail    = buf_en ? (cnt_ff != 5'h00) : hv_ff;
  assign fill     = buf_en ? cnt_ff : 5'(hv_ff);
  assign hold_vld = hv_ff;
endmodule : utx_rxq

// file: verilog/utx_sync.sv
// utx_sync: three-stage input synchroniser with agreement filter.
// assumes an asynchronous pin input and one system clock.
module utx_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout  <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule : utx_sync
